// File: verilog/vepc_pin_control.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "vepc_consts.svh"

module vepc_pin_control
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic [3:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output      logic [15:0]           reg_rdata,
    input  wire logic [7:0]            pixel_bus,
    input  wire logic                  blank_n_in,
    input  wire logic                  hsync_in,
    output      logic                  hsync_out,
    output      logic                  hsync_oe,
    input  wire logic                  field_vsync_in,
    output      logic                  field_vsync_out,
    output      logic                  field_vsync_oe,
    input  wire logic                  subcarrier_reset_or_lock_in,
    input  wire logic                  addr_lsb_select,
    input  wire logic                  mgmt_serial_clock,
    input  wire logic                  mgmt_serial_data_in,
    output      logic                  mgmt_serial_data_out,
    output      logic                  mgmt_serial_data_oe,
    output      logic [6:0]            mgmt_slave_addr,
    input  wire logic                  teletext_in,
    output      logic                  teletext_request,
    output      vepc_pkg::vepc_pix_type pix_out,
    output      logic [2:0]            subcarrier_field,
    output      logic                  video_pal,
    output      logic [2:0]            dac_enable
);

    vepc_pkg::vepc_regs_type r_reg;
    vepc_pkg::vepc_regs_type r_next;
    vepc_pkg::vepc_trs_type  trs;

    logic [1:0]  tmode;
    logic [1:0]  lock_sel;
    logic        master;
    logic        pal;
    logic        sync_mode;
    logic        lock_rise;
    logic [10:0] line_len;
    logic [9:0]  field_lines;
    logic [2:0]  seq_last;

    // timing reference codes ride in the pixel stream
    vepc_trs_detect u_trs
    (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .byte_in    (pixel_bus),
        .byte_valid (blank_n_in),
        .trs        (trs)
    );

    // decoded mode fields
    assign tmode       = r_reg.mode0[`VEPC_M0_TMODE_HI:`VEPC_M0_TMODE_LO];
    assign master      = r_reg.mode0[`VEPC_M0_MASTER];
    assign pal         = r_reg.mode0[`VEPC_M0_PAL];
    assign lock_sel    = r_reg.mode2[`VEPC_M2_LOCKSEL_HI:`VEPC_M2_LOCKSEL_LO];
    assign sync_mode   = (tmode == `VEPC_TMODE_1) || (tmode == `VEPC_TMODE_2);
    assign lock_rise   = subcarrier_reset_or_lock_in && !r_reg.lock_prev;
    assign line_len    = pal ? `VEPC_LINE_PAL : `VEPC_LINE_NTSC;
    assign field_lines = pal ? `VEPC_LINES_PAL : `VEPC_LINES_NTSC;
    assign seq_last    = pal ? `VEPC_SEQ_LAST_PAL : `VEPC_SEQ_LAST_NTSC;

    // next-state logic
    always_comb
    begin
        r_next = r_reg;

        // register writes
        if (reg_wr && reg_addr == `VEPC_ADDR_MODE0)
            r_next.mode0 = reg_wdata[9:0];
        if (reg_wr && reg_addr == `VEPC_ADDR_MODE2)
            r_next.mode2 = reg_wdata[3:0];

        // register reads, data only in the following cycle
        r_next.rdata = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `VEPC_ADDR_MODE0:  r_next.rdata = {6'h00, r_reg.mode0};
                `VEPC_ADDR_MODE2:  r_next.rdata = {12'h000, r_reg.mode2};
                `VEPC_ADDR_STATUS: r_next.rdata = {9'h000, r_reg.hs_prev, r_reg.lock_active,
                                                   r_reg.seq, r_reg.field, r_reg.ttx_req};
                `VEPC_ADDR_LOCK:   r_next.rdata = r_reg.lock_period;
                `VEPC_ADDR_TTX:    r_next.rdata = {8'h00, r_reg.ttx_byte};
                default:           r_next.rdata = 16'h0000;
            endcase
        end

        // pixel capture: blanked bytes are dropped, sav realigns the component
        r_next.pix.valid = blank_n_in;
        if (blank_n_in)
        begin
            r_next.pix.data = pixel_bus;
            r_next.pix.comp = trs.sav ? 2'h0 : r_reg.pix.comp + 2'h1;
        end

        // sampled pin levels for edge detection
        r_next.hs_prev   = hsync_in;
        r_next.fv_prev   = field_vsync_in;
        r_next.lock_prev = subcarrier_reset_or_lock_in;

        // line and field timing
        if (master)
        begin
            if (r_reg.line_cnt >= line_len - 11'h001)
            begin
                r_next.line_cnt = 11'h000;
                if (r_reg.line_no >= field_lines - 10'h001)
                begin
                    r_next.line_no = 10'h000;
                    r_next.field   = ~r_reg.field;
                end
                else
                    r_next.line_no = r_reg.line_no + 10'h001;
            end
            else
                r_next.line_cnt = r_reg.line_cnt + 11'h001;
        end
        else if (sync_mode)
        begin
            // slave: external line sync restarts the line
            r_next.line_cnt = r_reg.line_cnt + 11'h001;
            if (hsync_in && !r_reg.hs_prev)
            begin
                r_next.line_cnt = 11'h000;
                r_next.line_no  = r_reg.line_no + 10'h001;
            end
            if (tmode == `VEPC_TMODE_1 && field_vsync_in != r_reg.fv_prev)
            begin
                r_next.field   = field_vsync_in;
                r_next.line_no = 10'h000;
            end
            if (tmode == `VEPC_TMODE_2 && field_vsync_in && !r_reg.fv_prev)
            begin
                r_next.field   = ~r_reg.field;
                r_next.line_no = 10'h000;
            end
        end
        else
        begin
            // slave mode 0: timing from embedded codes alone
            r_next.line_cnt = r_reg.line_cnt + 11'h001;
            if (trs.eav)
            begin
                r_next.line_cnt = 11'h000;
                r_next.line_no  = r_reg.line_no + 10'h001;
                if (trs.field != r_reg.field)
                begin
                    r_next.field   = trs.field;
                    r_next.line_no = 10'h000;
                end
            end
        end

        // sync pin drive, direction from master bit in timing modes 1 and 2
        r_next.hs_oe  = master && sync_mode;
        r_next.fv_oe  = master && sync_mode;
        r_next.hs_out = r_next.line_cnt < `VEPC_HS_WIDTH;
        r_next.fv_out = (tmode == `VEPC_TMODE_2) ? (r_next.line_no < `VEPC_VS_LINES)
                                                 : r_next.field;

        // subcarrier field sequence, reset edge wins over advance
        if (r_next.field != r_reg.field)
            r_next.seq = (r_reg.seq >= seq_last) ? 3'h0 : r_reg.seq + 3'h1;
        if (lock_sel == `VEPC_LOCKSEL_RESET && lock_rise)
            r_next.seq = 3'h0;

        // external lock: measure period between rising edges
        if (lock_sel == `VEPC_LOCKSEL_LOCK)
        begin
            if (lock_rise)
            begin
                r_next.lock_period = r_reg.lock_cnt;
                r_next.lock_cnt    = 16'h0000;
                r_next.lock_active = 1'b1;
            end
            else if (r_reg.lock_cnt != 16'hFFFF)
                r_next.lock_cnt = r_reg.lock_cnt + 16'h0001;
            else
                r_next.lock_active = 1'b0;
        end
        else
        begin
            r_next.lock_cnt    = 16'h0000;
            r_next.lock_active = 1'b0;
        end

        // teletext request in the vbi window when insertion is on
        r_next.ttx_req = r_reg.mode2[`VEPC_M2_TTX_EN]
                         && r_reg.line_no >= `VEPC_TTX_FIRST
                         && r_reg.line_no <= `VEPC_TTX_LAST;
        if (r_reg.ttx_req)
        begin
            r_next.ttx_sh   = {r_reg.ttx_sh[6:0], teletext_in};
            r_next.ttx_bits = r_reg.ttx_bits + 3'h1;
            if (r_reg.ttx_bits == 3'h7)
                r_next.ttx_byte = {r_reg.ttx_sh[6:0], teletext_in};
        end

        // management address lsb follows the select pin
        r_next.mgmt_addr = {6'(`VEPC_MGMT_ADDR_BASE >> 1), addr_lsb_select};
    end

    // state register with reset defaults
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_reg       <= '0;
            r_reg.mode0 <= `VEPC_MODE0_RST;
            r_reg.mode2 <= `VEPC_MODE2_RST;
            r_reg.mgmt_addr <= `VEPC_MGMT_ADDR_BASE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state, serial data out and its enable tied low
    assign reg_rdata            = r_reg.rdata;
    assign pix_out              = r_reg.pix;
    assign hsync_out            = r_reg.hs_out;
    assign hsync_oe             = r_reg.hs_oe;
    assign field_vsync_out      = r_reg.fv_out;
    assign field_vsync_oe       = r_reg.fv_oe;
    assign mgmt_slave_addr      = r_reg.mgmt_addr;
    assign mgmt_serial_data_out = 1'b0;
    assign mgmt_serial_data_oe  = 1'b0;
    assign teletext_request     = r_reg.ttx_req;
    assign subcarrier_field     = r_reg.seq;
    assign video_pal            = r_reg.mode0[`VEPC_M0_PAL];
    assign dac_enable           = r_reg.mode0[`VEPC_M0_DACEN_HI:`VEPC_M0_DACEN_LO];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_hs_rise;
        !hsync_in ##1 hsync_in;
    endsequence

    property p_blank_ignored;
        !blank_n_in |=> !pix_out.valid && $stable(pix_out.data);
    endproperty
    a_blank_ignored: assert property (p_blank_ignored) else $error("blanked byte taken");

    property p_pix_sample;
        blank_n_in |=> pix_out.valid && pix_out.data == $past(pixel_bus);
    endproperty
    a_pix_sample: assert property (p_pix_sample) else $error("pixel not sampled");

    property p_hs_dir;
        ##1 hsync_oe == $past(master && sync_mode);
    endproperty
    a_hs_dir: assert property (p_hs_dir) else $error("line sync direction wrong");

    property p_fv_dir;
        ##1 field_vsync_oe == $past(master && sync_mode);
    endproperty
    a_fv_dir: assert property (p_fv_dir) else $error("field pin direction wrong");

    property p_slave_line;
        !master && sync_mode ##0 s_hs_rise ##0 !master && sync_mode
        |=> r_reg.line_cnt == 11'h000;
    endproperty
    a_slave_line: assert property (p_slave_line) else $error("slave line not restarted");

    property p_screset;
        lock_sel == `VEPC_LOCKSEL_RESET && lock_rise |=> subcarrier_field == 3'h0;
    endproperty
    a_screset: assert property (p_screset) else $error("subcarrier not reset");

    property p_lock;
        lock_sel == `VEPC_LOCKSEL_LOCK && lock_rise ##1 lock_sel == `VEPC_LOCKSEL_LOCK
        |-> r_reg.lock_active && r_reg.lock_cnt == 16'h0000;
    endproperty
    a_lock: assert property (p_lock) else $error("lock edge not taken");

    property p_addr_lsb;
        ##1 mgmt_slave_addr[0] == $past(addr_lsb_select);
    endproperty
    a_addr_lsb: assert property (p_addr_lsb) else $error("address lsb wrong");

    property p_reset_default;
        $fell(sys_rst) |-> r_reg.mode0 == `VEPC_MODE0_RST && !hsync_oe;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("bad reset default");

    property p_ttx_off;
        !r_reg.mode2[`VEPC_M2_TTX_EN] |=> !teletext_request;
    endproperty
    a_ttx_off: assert property (p_ttx_off) else $error("teletext request raised");

    property p_sav_align;
        trs.sav && blank_n_in |=> pix_out.comp == 2'h0;
    endproperty
    a_sav_align: assert property (p_sav_align) else $error("pixel not realigned");

endmodule // vepc_pin_control

// File: verilog/vepc_consts.svh
`ifndef VEPC_CONSTS_SVH
`define VEPC_CONSTS_SVH

// register addresses
`define VEPC_ADDR_MODE0      4'h0
`define VEPC_ADDR_MODE2      4'h1
`define VEPC_ADDR_STATUS     4'h2
`define VEPC_ADDR_LOCK       4'h3
`define VEPC_ADDR_TTX        4'h4

// mode 0 fields and reset value: ntsc, slave, timing mode 0, 8-bit, composite, dacs on
`define VEPC_M0_PAL          0
`define VEPC_M0_TMODE_LO     1
`define VEPC_M0_TMODE_HI     2
`define VEPC_M0_MASTER       3
`define VEPC_M0_WIDE_IN      4
`define VEPC_M0_DACSEL_LO    5
`define VEPC_M0_DACSEL_HI    6
`define VEPC_M0_DACEN_LO     7
`define VEPC_M0_DACEN_HI     9
`define VEPC_MODE0_RST       10'h380

// mode 2 fields and reset value
`define VEPC_M2_LOCKSEL_LO   1
`define VEPC_M2_LOCKSEL_HI   2
`define VEPC_M2_TTX_EN       3
`define VEPC_MODE2_RST       4'h0
`define VEPC_LOCKSEL_RESET   2'h1
`define VEPC_LOCKSEL_LOCK    2'h2

// timing modes
`define VEPC_TMODE_0         2'h0
`define VEPC_TMODE_1         2'h1
`define VEPC_TMODE_2         2'h2

// timing counts in clock cycles, lines and fields
`define VEPC_LINE_NTSC       11'h6B4
`define VEPC_LINE_PAL        11'h6C0
`define VEPC_HS_WIDTH        11'h080
`define VEPC_LINES_NTSC      10'h106
`define VEPC_LINES_PAL       10'h138
`define VEPC_VS_LINES        10'h003
`define VEPC_TTX_FIRST       10'h007
`define VEPC_TTX_LAST        10'h016
`define VEPC_SEQ_LAST_NTSC   3'h3
`define VEPC_SEQ_LAST_PAL    3'h7

// management slave address, upper bits arbitrary
`define VEPC_MGMT_ADDR_BASE  7'h2A

// timing reference code bytes
`define VEPC_TRS_FF          8'hFF
`define VEPC_TRS_00          8'h00

`endif

// File: verilog/vepc_pkg.sv
package vepc_pkg;

    // timing reference detector states
    typedef enum logic [3:0]
    {
        VEPC_TRS_IDLE = 4'h1,
        VEPC_TRS_FF   = 4'h2,
        VEPC_TRS_Z1   = 4'h4,
        VEPC_TRS_Z2   = 4'h8
    } vepc_trs_state_type;

    // decoded timing reference code
    typedef struct packed
    {
        logic sav;
        logic eav;
        logic field;
        logic vblank;
    } vepc_trs_type;

    // demultiplexed pixel byte
    typedef struct packed
    {
        logic       valid;
        logic [1:0] comp;
        logic [7:0] data;
    } vepc_pix_type;

    typedef struct packed
    {
        vepc_trs_state_type st;
        vepc_trs_type       trs;
    } vepc_trs_regs_type;

    typedef struct packed
    {
        logic [9:0]   mode0;
        logic [3:0]   mode2;
        logic [15:0]  rdata;
        vepc_pix_type pix;
        logic [10:0]  line_cnt;
        logic [9:0]   line_no;
        logic         field;
        logic [2:0]   seq;
        logic         hs_out;
        logic         hs_oe;
        logic         fv_out;
        logic         fv_oe;
        logic         hs_prev;
        logic         fv_prev;
        logic         lock_prev;
        logic [15:0]  lock_cnt;
        logic [15:0]  lock_period;
        logic         lock_active;
        logic         ttx_req;
        logic [7:0]   ttx_sh;
        logic [2:0]   ttx_bits;
        logic [7:0]   ttx_byte;
        logic [6:0]   mgmt_addr;
    } vepc_regs_type;

endpackage

// File: verilog/vepc_trs_detect.sv
`timescale 1ns/1ns
`include "vepc_consts.svh"

module vepc_trs_detect
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic [7:0]            byte_in,
    input  wire logic                  byte_valid,
    output vepc_pkg::vepc_trs_type     trs
);

    vepc_pkg::vepc_trs_regs_type r_reg;
    vepc_pkg::vepc_trs_regs_type r_next;

    // walk ff 00 00 then decode the xy byte
    always_comb
    begin
        r_next = r_reg;
        r_next.trs = '0;
        if (byte_valid)
        begin
            case (r_reg.st)
                vepc_pkg::VEPC_TRS_IDLE:
                    if (byte_in == `VEPC_TRS_FF) r_next.st = vepc_pkg::VEPC_TRS_FF;
                vepc_pkg::VEPC_TRS_FF:
                    r_next.st = (byte_in == `VEPC_TRS_00) ? vepc_pkg::VEPC_TRS_Z1
                                                        : vepc_pkg::VEPC_TRS_IDLE;
                vepc_pkg::VEPC_TRS_Z1:
                    r_next.st = (byte_in == `VEPC_TRS_00) ? vepc_pkg::VEPC_TRS_Z2
                                                        : vepc_pkg::VEPC_TRS_IDLE;
                vepc_pkg::VEPC_TRS_Z2:
                begin
                    r_next.st         = vepc_pkg::VEPC_TRS_IDLE;
                    r_next.trs.sav    = ~byte_in[4];
                    r_next.trs.eav    = byte_in[4];
                    r_next.trs.field  = byte_in[6];
                    r_next.trs.vblank = byte_in[5];
                end
                default:
                    r_next.st = vepc_pkg::VEPC_TRS_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_reg.st  <= vepc_pkg::VEPC_TRS_IDLE;
            r_reg.trs <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign trs = r_reg.trs;

    // code is reported one cycle after ff 00 00 xy
    sequence s_preamble;
        byte_valid && byte_in == `VEPC_TRS_FF ##1 byte_valid && byte_in == `VEPC_TRS_00
        ##1 byte_valid && byte_in == `VEPC_TRS_00;
    endsequence
    property p_trs_found;
        @(posedge core_clk) disable iff (sys_rst)
        s_preamble ##1 byte_valid |=> (trs.sav || trs.eav);
    endproperty
    a_trs_found: assert property (p_trs_found) else $error("code not reported");

endmodule // vepc_trs_detect

// File: tb/vepc_video_source.sv
`timescale 1ns/1ns

module vepc_video_source
(
    input  wire logic       core_clk,
    output      logic [7:0] pixel_bus,
    output      logic       blank_n_in,
    output      logic       hsync_in,
    output      logic       field_vsync_in
);
    // idle levels from time zero
    initial
    begin
        pixel_bus      = 8'h00;
        blank_n_in     = 1'b0;
        hsync_in       = 1'b0;
        field_vsync_in = 1'b0;
    end

    // one multiplexed byte per reference clock, lsb on bit 0
    task automatic put(input logic [7:0] b, input logic blank_n);
        @(posedge core_clk);
        pixel_bus  <= b;
        blank_n_in <= blank_n;
    endtask

    // line sync pulse while the encoder is timing slave
    task automatic line_pulse(input int width);
        @(posedge core_clk);
        hsync_in <= 1'b1;
        repeat (width) @(posedge core_clk);
        hsync_in <= 1'b0;
    endtask
endmodule // vepc_video_source

// File: tb/vepc_pin_control_test.sv
`timescale 1ns/1ns
`include "vepc_consts.svh"

module vepc_pin_control_test;
    logic                   core_clk;
    logic                   sys_rst;
    logic [3:0]             reg_addr;
    logic [15:0]            reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [15:0]            reg_rdata;
    logic [7:0]             pixel_bus;
    logic                   blank_n_in;
    logic                   hsync_in;
    logic                   hsync_out;
    logic                   hsync_oe;
    logic                   field_vsync_in;
    logic                   field_vsync_out;
    logic                   field_vsync_oe;
    logic                   lock_pin;
    logic                   addr_lsb_select;
    logic                   sda_out;
    logic                   sda_oe;
    logic                   sda_wire;
    logic [6:0]             mgmt_slave_addr;
    logic                   teletext_in;
    logic                   teletext_request;
    vepc_pkg::vepc_pix_type pix_out;
    logic [2:0]             subcarrier_field;
    logic                   video_pal;
    logic [2:0]             dac_enable;
    logic [15:0]            d;
    logic [1:0]             c;
    int                     miscompares;
    int                     compares;
    int                     hi;
    int                     lo;
    logic [7:0]             pb [10] = '{8'hFF, 8'h00, 8'h00, 8'h80, 8'h01,
                                        8'h10, 8'h80, 8'hF0, 8'h5A, 8'h3C};

    // steady reference clock
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    // open-drain data line with pull-up
    assign sda_wire = sda_oe ? sda_out : 1'b1;

    vepc_video_source src
    (
        .core_clk       (core_clk),
        .pixel_bus      (pixel_bus),
        .blank_n_in     (blank_n_in),
        .hsync_in       (hsync_in),
        .field_vsync_in (field_vsync_in)
    );

    vepc_pin_control dut
    (
        .core_clk                    (core_clk),
        .sys_rst                     (sys_rst),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_wr                      (reg_wr),
        .reg_rd                      (reg_rd),
        .reg_rdata                   (reg_rdata),
        .pixel_bus                   (pixel_bus),
        .blank_n_in                  (blank_n_in),
        .hsync_in                    (hsync_in),
        .hsync_out                   (hsync_out),
        .hsync_oe                    (hsync_oe),
        .field_vsync_in              (field_vsync_in),
        .field_vsync_out             (field_vsync_out),
        .field_vsync_oe              (field_vsync_oe),
        .subcarrier_reset_or_lock_in (lock_pin),
        .addr_lsb_select             (addr_lsb_select),
        .mgmt_serial_clock           (1'b1),
        .mgmt_serial_data_in         (sda_wire),
        .mgmt_serial_data_out        (sda_out),
        .mgmt_serial_data_oe         (sda_oe),
        .mgmt_slave_addr             (mgmt_slave_addr),
        .teletext_in                 (teletext_in),
        .teletext_request            (teletext_request),
        .pix_out                     (pix_out),
        .subcarrier_field            (subcarrier_field),
        .video_pal                   (video_pal),
        .dac_enable                  (dac_enable)
    );

    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for a level, counting cycles
    task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v)
        begin
            @(negedge core_clk);
            n++;
            if (n > lim)
            begin
                miscompares++;
                $display("timeout at %0t", $time);
                conclude();
            end
        end
    endtask

    // register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // register read, data in the following cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        rd(a, d);
        check(d, exp);
    endtask

    // one-cycle high pulse on the dual-use pin
    task automatic lock_pulse();
        @(posedge core_clk);
        lock_pin <= 1'b1;
        @(posedge core_clk);
        lock_pin <= 1'b0;
    endtask

    // main sequence
    initial
    begin
        sys_rst         = 1'b1;
        reg_addr        = 4'h0;
        reg_wdata       = 16'h0000;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        lock_pin        = 1'b0;
        addr_lsb_select = 1'b0;
        teletext_in     = 1'b1;
        miscompares     = 0;
        compares        = 0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check({9'h000, mgmt_slave_addr}, {9'h000, `VEPC_MGMT_ADDR_BASE});
        check({13'h0000, dac_enable}, 16'h0007);
        check({14'h0000, video_pal, hsync_oe}, 16'h0000);
        check({13'h0000, teletext_request, sda_oe, sda_out}, 16'h0000);
        rdc(`VEPC_ADDR_MODE0, {6'h00, `VEPC_MODE0_RST});
        repeat (2) @(negedge core_clk);
        check(reg_rdata, 16'h0000);
        rdc(`VEPC_ADDR_MODE2, 16'h0000);
        rdc(4'hF, 16'h0000);
        wr(`VEPC_ADDR_LOCK, 16'hFFFF);
        rdc(`VEPC_ADDR_LOCK, 16'h0000);
        @(posedge core_clk);
        addr_lsb_select <= 1'b1;
        repeat (2) @(negedge core_clk);
        check({9'h000, mgmt_slave_addr}, {9'h000, `VEPC_MGMT_ADDR_BASE | 7'h01});
        $display("test reset_and_address done");

        // start code, then samples with two blanked bytes
        c = 2'h0;
        for (int i = 0; i < 11; i++)
        begin
            src.put(i < 10 ? pb[i] : 8'hC3, !(i == 8 || i == 10));
            @(negedge core_clk);
            if (i > 0 && i != 9)
                check({7'h00, pix_out.valid, pix_out.data}, {8'h01, pb[i - 1]});
            if (i == 9)
                check({7'h00, pix_out.valid, pix_out.data}, {8'h00, pb[7]});
            if (i > 4 && i != 9)
            begin
                check({14'h0000, pix_out.comp}, {14'h0000, c});
                c++;
            end
        end
        $display("test pixel_port done");

        // master timing mode 1 with teletext insertion
        wr(`VEPC_ADDR_MODE0, 16'h038A);
        wr(`VEPC_ADDR_MODE2, 16'h0008);
        @(negedge core_clk);
        check({14'h0000, hsync_oe, field_vsync_oe}, 16'h0003);
        wait_for(teletext_request, 1'b1, 50000, hi);
        repeat (20) @(posedge core_clk);
        rdc(`VEPC_ADDR_TTX, 16'h00FF);
        wr(`VEPC_ADDR_MODE2, 16'h0000);
        repeat (3) @(negedge core_clk);
        check({15'h0000, teletext_request}, 16'h0000);
        $display("test teletext done");

        // slave mode 0: an eav code with field bit set advances the sequence
        wr(`VEPC_ADDR_MODE0, 16'h0380);
        for (int i = 0; i < 4; i++)
            src.put(pb[i < 3 ? i : 7], 1'b1);
        repeat (3) @(negedge core_clk);
        check({12'h000, field_vsync_out, subcarrier_field}, 16'h0009);
        // subcarrier reset, then external lock, then pin unused
        wr(`VEPC_ADDR_MODE2, 16'h0002);
        lock_pulse();
        repeat (2) @(negedge core_clk);
        check({13'h0000, subcarrier_field}, 16'h0000);
        wr(`VEPC_ADDR_MODE2, 16'h0004);
        lock_pulse();
        repeat (98) @(posedge core_clk);
        lock_pulse();
        repeat (3) @(posedge core_clk);
        rdc(`VEPC_ADDR_LOCK, 16'h0063);
        rd(`VEPC_ADDR_STATUS, d);
        check({15'h0000, d[5]}, 16'h0001);
        wr(`VEPC_ADDR_MODE2, 16'h0000);
        lock_pulse();
        repeat (48) @(posedge core_clk);
        lock_pulse();
        repeat (3) @(posedge core_clk);
        rdc(`VEPC_ADDR_LOCK, 16'h0063);
        $display("test lock_pin done");

        // line sync width and period for both standards
        for (int p = 0; p < 2; p++)
        begin
            wr(`VEPC_ADDR_MODE0, p == 1 ? 16'h038B : 16'h038A);
            wait_for(hsync_out, 1'b0, 2000, hi);
            wait_for(hsync_out, 1'b1, 2000, hi);
            wait_for(hsync_out, 1'b0, 2000, hi);
            wait_for(hsync_out, 1'b1, 2000, hi);
            wait_for(hsync_out, 1'b0, 2000, hi);
            wait_for(hsync_out, 1'b1, 2000, lo);
            check(hi[15:0], {5'h00, `VEPC_HS_WIDTH});
            check(hi[15:0] + lo[15:0],
                  {5'h00, p == 1 ? `VEPC_LINE_PAL : `VEPC_LINE_NTSC});
            check({15'h0000, video_pal}, p[15:0]);
        end
        $display("test master_sync done");

        // pin direction for each timing mode
        wr(`VEPC_ADDR_MODE0, 16'h038C);
        repeat (2) @(negedge core_clk);
        check({14'h0000, hsync_oe, field_vsync_oe}, 16'h0003);
        wr(`VEPC_ADDR_MODE0, 16'h0388);
        repeat (2) @(negedge core_clk);
        check({14'h0000, hsync_oe, field_vsync_oe}, 16'h0000);
        wr(`VEPC_ADDR_MODE0, 16'h0382);
        src.line_pulse(8);
        @(negedge core_clk);
        check({14'h0000, hsync_oe, field_vsync_oe}, 16'h0000);
        $display("test pin_direction done");
        conclude();
    end
endmodule // vepc_pin_control_test
